// File: led_defines.svh
/*
 * Register offsets, field positions, reset values and timing for the
 * network status LED driver.
 * Assumes inclusion by bare name from each design file that needs it.
 */
`ifndef LED_DEFINES_SVH
`define LED_DEFINES_SVH

// register word addresses on the plain register port
`define ADDR_LINK_LED_STATUS  4'h4
`define ADDR_LED_ONE_CONFIG   4'h5
`define ADDR_DUPLEX_CONTROL   4'h9

// link_led_status fields
`define LNK_GOOD_BIT          15

// led_one_config fields
`define L1_RAW_BIT            15
`define L1_WAKE_BIT           9
`define L1_FDXLINK_BIT        8
`define L1_STRETCH_BIT        7
`define L1_MATCH_BIT          5
`define L1_TX_BIT             4
`define L1_POL_BIT            3
`define L1_RX_BIT             2
`define L1_JAB_BIT            1
`define L1_COL_BIT            0
// writable bits: 9..7 and 5..0; reserved 14..10 and 6 read as zero
`define L1_WRITE_MASK         16'h03BF
// receive status with stretcher on
`define L1_RESET_VALUE        16'h0084

// duplex_control_reg fields
`define DPX_FULL_BIT          0
`define DPX_AUI_FDX_BIT       1
`define DPX_WRITE_MASK        16'h0003
`define DPX_RESET_VALUE       16'h0000

// stretch time after the last occurrence
`define STRETCH_TIME_MS       50
`define CLK_FREQ_HZ           100000000
// divide first: the product of the two overflows a 32-bit int
`define STRETCH_CYCLES        (`STRETCH_TIME_MS * (`CLK_FREQ_HZ / 1000))

`endif

// File: led_pkg.sv
/*
 * Types shared by the LED driver files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package led_pkg;
    typedef enum logic [1:0] {
        PORT_TWISTED_PAIR,
        PORT_ATTACH_UNIT,
        PORT_GP_SERIAL
    } active_port_t;
    typedef logic [15:0] reg_word_t;
endpackage

// File: fdx_link_status.sv
/*
 * Full-duplex link indication for the selected port.
 * Assumes all inputs are synchronous to sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module fdx_link_status (
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire led_pkg::active_port_t active_port,
    input  wire logic                  link_pass,
    input  wire logic                  duplex_full_en,
    input  wire logic                  attach_unit_fdx_en,
    output logic                       fdx_link_q
);
    import led_pkg::*;

    logic fdx_link_d;

    always_comb begin
        unique case (active_port)
            PORT_TWISTED_PAIR: fdx_link_d = link_pass
                                            && duplex_full_en;
            PORT_ATTACH_UNIT:  fdx_link_d = duplex_full_en
                                            && attach_unit_fdx_en;
            PORT_GP_SERIAL:    fdx_link_d = duplex_full_en;
            default:           fdx_link_d = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fdx_link_q <= 1'b0;
        end else begin
            fdx_link_q <= fdx_link_d;
        end
    end
endmodule // fdx_link_status

`default_nettype wire

// File: pulse_stretcher.sv
/*
 * Retriggerable pulse stretcher.
 * Assumes a synchronous level input; count length is a parameter.
 */
`timescale 1ns/10ps
`default_nettype none

module pulse_stretcher #(
    parameter int unsigned HOLD_CYCLES = 5000000
) (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic enable,
    input  wire logic level_in,
    output logic      level_out_q
);
    localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);

    // refused at elaboration: a zero hold leaves the counter no width
    if (HOLD_CYCLES < 1) begin : g_bad_hold
        $error("HOLD_CYCLES must be at least one");
    end

    logic [CW-1:0] count_q;

    // reload on every active cycle so that the hold runs from the last one
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count_q <= '0;
        end else if (level_in) begin
            count_q <= CW'(HOLD_CYCLES);
        end else if (count_q != '0) begin
            count_q <= count_q - CW'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            level_out_q <= 1'b0;
        end else if (enable) begin
            level_out_q <= level_in || (count_q > CW'(1));
        end else begin
            level_out_q <= level_in;
        end
    end
endmodule // pulse_stretcher

`default_nettype wire

// File: network_status_led_driver.sv
/*
 * Network status LED driver: fixed link LED and programmable LED one,
 * with their configuration and status registers.
 * Assumes a plain register port with read data one cycle after the
 * read strobe, and event inputs synchronous to sys_clk.
 */
// The plain strobed port and the address map are this design's own decisions.
// Notes on behaviour
// - link LED shows transceiver link only
// - link status bit 15 mirrors link LED
// - full-duplex conditions mask the link LED
// - link status low bits read zero
// - LED one bit 15 is raw state
// - LED one reserved bits read zero
// - bit 9 shows wake-up frame received
// - bit 8 adds full-duplex link status
// - twisted pair: link pass and duplex enable
// - attach unit: both duplex enables set
// - serial port: duplex enable set
// - bit 7 turns pulse stretching on
// - bit 5 limits receive to matches
// - bit 4 includes transmit activity
// - bit 3 shows correct receive polarity
// - bit 2 includes receive activity
// - bit 1 includes jabber
// - bit 0 includes collision
// - reset value has stretcher enabled
// - pin is OR; default receive only
`timescale 1ns/10ps
`default_nettype none
`include "led_defines.svh"

module network_status_led_driver #(
    parameter int unsigned STRETCH_CYCLES = `STRETCH_CYCLES
) (
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic [3:0]        reg_addr,
    input  wire led_pkg::reg_word_t reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output led_pkg::reg_word_t     reg_rdata,
    input  wire led_pkg::active_port_t active_port,
    input  wire logic              tp_link_pass,
    input  wire logic              tp_full_duplex,
    input  wire logic              other_fdx_link_led_en,
    input  wire logic              rx_activity,
    input  wire logic              rx_addr_match,
    input  wire logic              tx_activity,
    input  wire logic              jabber,
    input  wire logic              collision,
    input  wire logic              polarity_ok,
    input  wire logic              wake_frame_rcvd,
    output logic                   link_led_pin_n,
    output logic                   led_one_pin_n
);
    import led_pkg::*;

    // refused at elaboration: the stretcher needs a hold of one or more
    if (STRETCH_CYCLES < 1) begin : g_bad_stretch
        $error("STRETCH_CYCLES must be at least one");
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    reg_word_t led_one_q;
    reg_word_t duplex_q;
    reg_word_t rdata_q;
    logic      link_good_flag;
    logic      led_raw_state;

    // only writable bits are stored, so reserved bits stay zero
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            led_one_q <= `L1_RESET_VALUE;
        end else if (reg_write && reg_addr == `ADDR_LED_ONE_CONFIG) begin
            led_one_q <= reg_wdata & `L1_WRITE_MASK;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            duplex_q <= `DPX_RESET_VALUE;
        end else if (reg_write && reg_addr == `ADDR_DUPLEX_CONTROL) begin
            duplex_q <= reg_wdata & `DPX_WRITE_MASK;
        end
    end

    // link status is read only; writes there are ignored
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdata_q <= 16'h0000;
        end else if (reg_read) begin
            unique case (reg_addr)
                `ADDR_LINK_LED_STATUS: begin
                    rdata_q <= {link_good_flag, 15'h0000};
                end
                `ADDR_LED_ONE_CONFIG: begin
                    rdata_q <= {led_raw_state, 15'h0000}
                               | led_one_q;
                end
                `ADDR_DUPLEX_CONTROL: rdata_q <= duplex_q;
                default:              rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////
    // field decode

    logic duplex_full_en;
    logic attach_unit_fdx_en;
    logic wake_frame_led_en;
    logic fdx_link_led_en;
    logic stretch_en;
    logic match_only_rx_led;
    logic tx_activity_led_en;
    logic polarity_ok_led_en;
    logic rx_activity_led_en;
    logic jabber_led_en;
    logic collision_led_en;

    assign duplex_full_en     = duplex_q[`DPX_FULL_BIT];
    assign attach_unit_fdx_en = duplex_q[`DPX_AUI_FDX_BIT];
    assign wake_frame_led_en  = led_one_q[`L1_WAKE_BIT];
    assign fdx_link_led_en    = led_one_q[`L1_FDXLINK_BIT];
    assign stretch_en         = led_one_q[`L1_STRETCH_BIT];
    assign match_only_rx_led  = led_one_q[`L1_MATCH_BIT];
    assign tx_activity_led_en = led_one_q[`L1_TX_BIT];
    assign polarity_ok_led_en = led_one_q[`L1_POL_BIT];
    assign rx_activity_led_en = led_one_q[`L1_RX_BIT];
    assign jabber_led_en      = led_one_q[`L1_JAB_BIT];
    assign collision_led_en   = led_one_q[`L1_COL_BIT];

    ////////////////////////////////////////////////////////////////////
    // link LED

    logic link_mask;
    logic link_led_q;

    // other_fdx_link_led_en carries the same enable of the other LED
    // registers, which live outside this block
    assign link_mask = tp_full_duplex && !attach_unit_fdx_en
                       && (fdx_link_led_en
                           || other_fdx_link_led_en);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            link_led_q <= 1'b0;
        end else begin
            link_led_q <= tp_link_pass && !link_mask;
        end
    end

    assign link_good_flag = link_led_q;
    assign link_led_pin_n = !link_led_q;

    ////////////////////////////////////////////////////////////////////
    // LED one combined state

    logic fdx_link_q;

    fdx_link_status u_fdx_link (
        .sys_clk            (sys_clk),
        .reset              (reset),
        .active_port        (active_port),
        .link_pass          (tp_link_pass),
        .duplex_full_en     (duplex_full_en),
        .attach_unit_fdx_en (attach_unit_fdx_en),
        .fdx_link_q         (fdx_link_q)
    );

    logic rx_qualified;
    logic raw_d;
    logic raw_q;

    assign rx_qualified = rx_activity
                          && (!match_only_rx_led || rx_addr_match);

    always_comb begin
        raw_d = 1'b0;
        raw_d = raw_d || (wake_frame_led_en && wake_frame_rcvd);
        raw_d = raw_d || (fdx_link_led_en && fdx_link_q);
        raw_d = raw_d || (tx_activity_led_en && tx_activity);
        raw_d = raw_d || (polarity_ok_led_en && polarity_ok);
        raw_d = raw_d || (rx_activity_led_en && rx_qualified);
        raw_d = raw_d || (jabber_led_en && jabber);
        raw_d = raw_d || (collision_led_en && collision);
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            raw_q <= 1'b0;
        end else begin
            raw_q <= raw_d;
        end
    end

    assign led_raw_state = raw_q;

    ////////////////////////////////////////////////////////////////////
    // stretcher and pin

    logic stretched_q;

    pulse_stretcher #(
        .HOLD_CYCLES (STRETCH_CYCLES)
    ) u_stretch (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .enable      (stretch_en),
        .level_in    (raw_q),
        .level_out_q (stretched_q)
    );

    assign led_one_pin_n = !stretched_q;
endmodule // network_status_led_driver

`default_nettype wire

// File: led_drv_chk_assertions.sv
/* Port checker for the network status LED driver.
   Assumes the design's register map and reset values; shadows the
   writable registers from the register port. */
`timescale 1ns/10ps
`default_nettype none
`include "led_defines.svh"
module led_drv_chk #(parameter int unsigned SC = 8) (
    input wire logic           sys_clk, reset, reg_write, reg_read,
    input wire logic [3:0]     reg_addr,
    input wire led_pkg::reg_word_t reg_wdata, reg_rdata,
    input wire led_pkg::active_port_t active_port,
    input wire logic           tp_link_pass, tp_full_duplex,
    input wire logic           other_fdx_link_led_en, rx_activity,
    input wire logic           rx_addr_match, tx_activity, jabber,
    input wire logic           collision, polarity_ok, wake_frame_rcvd,
    input wire logic           link_led_pin_n, led_one_pin_n
);
    import led_pkg::*;
    reg_word_t  cfg_q;
    logic [1:0] dpx_q;
    int         q_cnt, lo_cnt;
    logic       any_ev, lk;
    // any input that could light led one, enabled or not
    assign any_ev = rx_activity | tx_activity | jabber | collision
                  | polarity_ok | wake_frame_rcvd | cfg_q[8];
    assign lk = tp_link_pass & ~(tp_full_duplex & ~dpx_q[1]
              & (cfg_q[8] | other_fdx_link_led_en));
    always_ff @(posedge sys_clk or posedge reset)
        if (reset) cfg_q <= `L1_RESET_VALUE;
        else if (reg_write && reg_addr == `ADDR_LED_ONE_CONFIG)
            cfg_q <= reg_wdata & `L1_WRITE_MASK;
    always_ff @(posedge sys_clk or posedge reset)
        if (reset) dpx_q <= 2'h0;
        else if (reg_write && reg_addr == `ADDR_DUPLEX_CONTROL)
            dpx_q <= reg_wdata[1:0];
    // counters saturate so a long idle cannot wrap them
    always_ff @(posedge sys_clk or posedge reset)
        if (reset) q_cnt <= 0;
        else q_cnt <= any_ev ? 0 : (q_cnt < SC + 9 ? q_cnt + 1 : q_cnt);
    always_ff @(posedge sys_clk or posedge reset)
        if (reset) lo_cnt <= 0;
        else lo_cnt <= led_one_pin_n ? 0
                     : (lo_cnt < SC + 9 ? lo_cnt + 1 : lo_cnt);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence quiet3;
        (!cfg_q[7] && !any_ev) [*3];
    endsequence
    chk_link_pin_map: assert property (
        !$past(reset) |-> link_led_pin_n == !$past(lk))
        else $error("link led pin wrong");
    chk_rdata_idle: assert property (
        !reg_read |=> reg_rdata == 16'h0000)
        else $error("read data not zero when idle");
    chk_status_read: assert property (
        reg_read && reg_addr == 4'h4 |=>
        reg_rdata == {~$past(link_led_pin_n), 15'h0000})
        else $error("link status read wrong");
    chk_cfg_read: assert property (
        reg_read && reg_addr == 4'h5 |=>
        reg_rdata[14:0] == $past(cfg_q[14:0]))
        else $error("led one config read wrong");
    chk_dpx_read: assert property (
        reg_read && reg_addr == 4'h9 |=> reg_rdata == {14'h0, $past(dpx_q)})
        else $error("duplex control read wrong");
    chk_nostretch_off: assert property (
        quiet3 |=> led_one_pin_n)
        else $error("led one lit without cause");
    chk_quiet_off: assert property (
        q_cnt > SC + 4 |-> led_one_pin_n)
        else $error("led one held too long");
    chk_stretch_hold: assert property (
        cfg_q[7] && $rose(led_one_pin_n) |-> lo_cnt >= SC - 1)
        else $error("led one stretch too short");
endmodule // led_drv_chk
bind network_status_led_driver led_drv_chk #(.SC(STRETCH_CYCLES)) i_chk (
    .sys_clk(sys_clk), .reset(reset), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .active_port(active_port),
    .tp_link_pass(tp_link_pass), .tp_full_duplex(tp_full_duplex),
    .other_fdx_link_led_en(other_fdx_link_led_en),
    .rx_activity(rx_activity), .rx_addr_match(rx_addr_match),
    .tx_activity(tx_activity), .jabber(jabber), .collision(collision),
    .polarity_ok(polarity_ok), .wake_frame_rcvd(wake_frame_rcvd),
    .link_led_pin_n(link_led_pin_n), .led_one_pin_n(led_one_pin_n));
`default_nettype wire

// File: led_lamp_model.sv
/* Indicator lamps on the adapter board.
   Assumes each lamp sinks current into its pin, lit while low. */
`timescale 1ns/10ps
`default_nettype none
module led_lamp_model (
    input  wire logic link_led_pin_n, led_one_pin_n,
    output logic      link_on, one_on
);
    assign link_on = ~link_led_pin_n;
    assign one_on  = ~led_one_pin_n;
endmodule // led_lamp_model
`default_nettype wire

// File: network_status_led_driver_tb.sv
/* Testbench for the LED driver: register tasks, event stimulus and
   lamp observation. Assumes a short stretch count for simulation. */
`timescale 1ns/10ps
`default_nettype none
`include "led_defines.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    n_mismatch++; $display("CHECK FAILED %s exp %h got %h", n, e, g); \
    end end
module network_status_led_driver_tb;
    import led_pkg::*;
    localparam int unsigned SC = 8;
    logic sys_clk = 0, reset = 1, reg_write = 0, reg_read = 0;
    logic [3:0] reg_addr = 4'h0;
    reg_word_t reg_wdata = 16'h0000, reg_rdata;
    active_port_t active_port = PORT_TWISTED_PAIR;
    logic tp_link_pass = 0, tp_full_duplex = 0, other_en = 0, match = 0;
    logic [5:0] ev = 6'h00; // wake, polarity, rx, jabber, collision, tx
    logic link_pin_n, one_pin_n, link_on, one_on;
    int n_mismatch = 0, cmp_count = 0, cyc = 0;
    int fb[6] = '{9, 3, 2, 1, 0, 4};
    int fd[6] = '{1, 0, 3, 1, 1, 0};
    always #5 sys_clk = ~sys_clk;
    network_status_led_driver #(.STRETCH_CYCLES(SC)) i_dut (
        .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .active_port(active_port), .tp_link_pass(tp_link_pass),
        .tp_full_duplex(tp_full_duplex), .other_fdx_link_led_en(other_en),
        .rx_activity(ev[2]), .rx_addr_match(match), .tx_activity(ev[5]),
        .jabber(ev[3]), .collision(ev[4]), .polarity_ok(ev[1]),
        .wake_frame_rcvd(ev[0]), .link_led_pin_n(link_pin_n),
        .led_one_pin_n(one_pin_n));
    led_lamp_model i_lamp (.link_led_pin_n(link_pin_n),
        .led_one_pin_n(one_pin_n), .link_on(link_on), .one_on(one_on));
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input reg_word_t d);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input reg_word_t e);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 `CHK("reg_rdata", e, reg_rdata)
    endtask
    task automatic put_ev(input logic [5:0] v);
        @(posedge sys_clk);
        ev <= v;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        rd(4'h5, 16'h0084);
        rd(4'h9, 16'h0000);
        rd(4'h3, 16'h0000);
        put_ev(6'h20);
        tick(3);
        `CHK("tx_default", 1'b0, one_on)
        put_ev(6'h04);
        tick(3);
        `CHK("rx_default", 1'b1, one_on)
        put_ev(6'h00);
        tick(SC + 6);
        wr(4'h5, 16'h03BF);
        rd(4'h5, 16'h03BF);
        wr(4'h5, 16'h0000);
        @(posedge sys_clk);
        tp_link_pass <= 1'b1;
        tick(2);
        `CHK("link_on", 1'b1, link_on)
        rd(4'h4, 16'h8000);
        wr(4'h4, 16'h0000);
        rd(4'h4, 16'h8000);
        @(posedge sys_clk);
        tp_full_duplex <= 1'b1;
        other_en <= 1'b1;
        tick(2);
        `CHK("link_mask", 1'b0, link_on)
        rd(4'h4, 16'h0000);
        wr(4'h9, 16'h0002);
        tick(2);
        `CHK("link_aui", 1'b1, link_on)
        wr(4'h9, 16'h0000);
        @(posedge sys_clk);
        other_en <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            wr(4'h5, 16'h0001 << fb[i]);
            put_ev(6'h01 << i);
            tick(3);
            `CHK("func_on", 1'b1, one_on)
            rd(4'h5, 16'h8000 | (16'h0001 << fb[i]));
            wr(4'h5, 16'h021F ^ (16'h0001 << fb[i]));
            tick(3);
            `CHK("func_off", 1'b0, one_on)
            put_ev(6'h00);
        end
        wr(4'h5, 16'h0024);
        put_ev(6'h04);
        tick(3);
        `CHK("rx_nomatch", 1'b0, one_on)
        @(posedge sys_clk);
        match <= 1'b1;
        tick(3);
        `CHK("rx_match", 1'b1, one_on)
        put_ev(6'h00);
        wr(4'h5, 16'h0100);
        for (int i = 0; i < 6; i++) begin
            @(posedge sys_clk);
            active_port <= active_port_t'(i / 2);
            wr(4'h9, 16'(fd[i]));
            tick(4);
            `CHK("fdx_link", 1'(i % 2 == 0), one_on)
            `CHK("link_fdx", 1'(fd[i] >> 1), link_on)
        end
        wr(4'h5, 16'h0094);
        put_ev(6'h04);
        put_ev(6'h00);
        tick(6);
        `CHK("stretch_hold", 1'b1, one_on)
        put_ev(6'h20);
        put_ev(6'h00);
        tick(SC);
        `CHK("retrigger", 1'b1, one_on)
        tick(SC);
        `CHK("stretch_end", 1'b0, one_on)
        wr(4'h5, 16'h0014);
        put_ev(6'h04);
        put_ev(6'h00);
        tick(4);
        `CHK("no_stretch", 1'b0, one_on)
        tally_and_finish;
    end
endmodule // network_status_led_driver_tb
`default_nettype wire
